// ===== rtl/dps_regs.svh
// Purpose: named offsets, field positions and reset values of the semaphore port
// Assumes: included by bare name
// Notes:   definitions only
`ifndef DPS_REGS_SVH
`define DPS_REGS_SVH

`define DPS_SEM_CNT    6
`define DPS_SEM_FIRST  8'h17
`define DPS_SEM_LAST   8'h1C
`define DPS_RAM_BASE   8'h80
`define DPS_RSVD_DATA  8'hFF
`define DPS_SEM_BIT    7
`define DPS_OWN_BIT    6
`define DPS_SEM_RST    6'h3F
`define DPS_OWN_RST    6'h3D
`define DPS_ZERO6      6'h00
`define DPS_ZERO8      8'h00

`endif

// ===== rtl/dps_pkg.sv
// Purpose: types shared by the semaphore port and its shared ram
// Assumes: dps_regs.svh on the include path
// Notes:   one-hot host access states
`include "dps_regs.svh"

package dps_pkg;

  typedef enum logic [4:0] {
    DPS_IDLE = 5'h01,
    DPS_ACC  = 5'h02,
    DPS_DATA = 5'h04,
    DPS_HOLD = 5'h08,
    DPS_REL  = 5'h10
  } dps_state_t;

  typedef struct packed {
    dps_state_t                st;
    logic                      e_m;
    logic                      e_s;
    logic                      e_d;
    logic                      cs_m;
    logic                      cs_s;
    logic                      dir_m;
    logic                      dir_s;
    logic                      mode_m;
    logic                      mode_s;
    logic [7:0]                addr_m;
    logic [7:0]                addr_s;
    logic [7:0]                din_m;
    logic [7:0]                din_s;
    logic [7:0]                h_addr;
    logic                      h_rd;
    logic [7:0]                h_wd;
    logic [7:0]                h_semv;
    logic [7:0]                h_dout;
    logic                      h_doe;
    logic                      ack_n;
    logic                      ack_oe;
    logic [`DPS_SEM_CNT-1:0]   sem;
    logic [`DPS_SEM_CNT-1:0]   own;
    logic                      c_p1;
    logic                      c_we1;
    logic                      c_sem1;
    logic                      c_ram1;
    logic [7:0]                c_semv1;
    logic [7:0]                c_rdata;
    logic                      c_ack;
  } dps_port_st_t;

  typedef struct packed {
    logic [127:0][7:0] mem;
    logic [7:0]        a_rdata;
    logic [7:0]        b_rdata;
  } dps_ram_st_t;

endpackage : dps_pkg

// ===== rtl/dps_ram.sv
// Purpose: 128-byte shared ram, one port per processor
// Assumes: same clock on both ports
// Notes:   read data registered; same-byte writes in one cycle let port b win
module dps_ram (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // port a, system side
  input  wire logic       a_en,
  input  wire logic       a_we,
  input  wire logic [6:0] a_addr,
  input  wire logic [7:0] a_wdata,
  output logic      [7:0] a_rdata,
  // port b, internal cpu side
  input  wire logic       b_en,
  input  wire logic       b_we,
  input  wire logic [6:0] b_addr,
  input  wire logic [7:0] b_wdata,
  output logic      [7:0] b_rdata
);

  dps_pkg::dps_ram_st_t q;
  dps_pkg::dps_ram_st_t nxt_q;

  always_comb begin
    nxt_q = q;
    if (a_en && a_we) begin
      nxt_q.mem[a_addr] = a_wdata;
    end
    if (b_en && b_we) begin
      nxt_q.mem[b_addr] = b_wdata;
    end
    nxt_q.a_rdata = q.mem[a_addr];
    nxt_q.b_rdata = q.mem[b_addr];
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= nxt_q;
    end
  end

  assign a_rdata = q.a_rdata;
  assign b_rdata = q.b_rdata;

endmodule : dps_ram

// ===== rtl/dps_port.sv
// Purpose: system-bus port of the shared ram with six test-and-set semaphores
// Assumes: host pins and phase clock asynchronous to clk_sys; cpu port on clk_sys
// Notes:   "same access" means the same clk_sys cycle for both sides
`include "dps_regs.svh"

module dps_port (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  // system bus pins
  input  wire logic       e_clk,
  input  wire logic       host_sync_mode,
  input  wire logic       host_cs_n,
  input  wire logic       host_dir,
  input  wire logic [7:0] host_addr,
  input  wire logic [7:0] host_data_in,
  output logic      [7:0] host_data_out,
  output logic            host_data_oe,
  output logic            xfer_ack_n,
  output logic            xfer_ack_oe,
  // internal cpu port
  input  wire logic       cpu_req,
  input  wire logic       cpu_we,
  input  wire logic [7:0] cpu_addr,
  input  wire logic [7:0] cpu_wdata,
  output logic      [7:0] cpu_rdata,
  output logic            cpu_ack
);

  logic                    rst_m_ff;
  logic                    rst_n;
  dps_pkg::dps_port_st_t   q;
  dps_pkg::dps_port_st_t   nxt_q;
  logic [`DPS_SEM_CNT-1:0] hr;
  logic [`DPS_SEM_CNT-1:0] hw;
  logic [`DPS_SEM_CNT-1:0] cr;
  logic [`DPS_SEM_CNT-1:0] cw;
  logic                    h_acc;
  logic                    h_ram;
  logic                    h_sem;
  logic                    c_ram;
  logic                    c_sem;
  logic [7:0]              ram_a_rdata;
  logic [7:0]              ram_b_rdata;
  logic                    e_rise;
  logic                    e_fall;

  // release of reset through two flops
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_ff <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_m_ff <= 1'b1;
      rst_n    <= rst_m_ff;
    end
  end

  assign e_rise = q.e_s & ~q.e_d;
  assign e_fall = ~q.e_s & q.e_d;
  assign h_acc  = (q.st == dps_pkg::DPS_ACC);
  assign h_ram  = (q.h_addr >= `DPS_RAM_BASE);
  assign h_sem  = (q.h_addr >= `DPS_SEM_FIRST) && (q.h_addr <= `DPS_SEM_LAST);
  assign c_ram  = (cpu_addr >= `DPS_RAM_BASE);
  assign c_sem  = (cpu_addr >= `DPS_SEM_FIRST) && (cpu_addr <= `DPS_SEM_LAST);

  // per-semaphore access decode, one bit per register in address order
  always_comb begin
    for (int i = 0; i < `DPS_SEM_CNT; i++) begin
      hr[i] = h_acc && q.h_rd && (q.h_addr == 8'(`DPS_SEM_FIRST + i));
      hw[i] = h_acc && !q.h_rd && (q.h_addr == 8'(`DPS_SEM_FIRST + i));
      cr[i] = cpu_req && !cpu_we && (cpu_addr == 8'(`DPS_SEM_FIRST + i));
      cw[i] = cpu_req && cpu_we && (cpu_addr == 8'(`DPS_SEM_FIRST + i));
    end
  end

  dps_ram u_ram (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .a_en    (h_acc && h_ram),
    .a_we    (!q.h_rd),
    .a_addr  (q.h_addr[6:0]),
    .a_wdata (q.h_wd),
    .a_rdata (ram_a_rdata),
    .b_en    (cpu_req && c_ram),
    .b_we    (cpu_we),
    .b_addr  (cpu_addr[6:0]),
    .b_wdata (cpu_wdata),
    .b_rdata (ram_b_rdata)
  );

  always_comb begin
    nxt_q = q;
    // pin synchronisers
    nxt_q.e_m    = e_clk;
    nxt_q.e_s    = q.e_m;
    nxt_q.e_d    = q.e_s;
    nxt_q.cs_m   = host_cs_n;
    nxt_q.cs_s   = q.cs_m;
    nxt_q.dir_m  = host_dir;
    nxt_q.dir_s  = q.dir_m;
    nxt_q.mode_m = host_sync_mode;
    nxt_q.mode_s = q.mode_m;
    nxt_q.addr_m = host_addr;
    nxt_q.addr_s = q.addr_m;
    nxt_q.din_m  = host_data_in;
    nxt_q.din_s  = q.din_m;

    // semaphore arbitration; cpu wins a tie on a clear lock
    nxt_q.h_semv = `DPS_ZERO8;
    nxt_q.c_semv1 = `DPS_ZERO8;
    for (int i = 0; i < `DPS_SEM_CNT; i++) begin
      if (hr[i]) begin
        nxt_q.h_semv[`DPS_SEM_BIT] = q.sem[i] | cr[i];
        nxt_q.h_semv[`DPS_OWN_BIT] = ~q.own[i];
      end
      if (cr[i]) begin
        nxt_q.c_semv1[`DPS_SEM_BIT] = q.sem[i];
        nxt_q.c_semv1[`DPS_OWN_BIT] = q.own[i];
      end
      if (hr[i] || cr[i]) begin
        nxt_q.sem[i] = (hw[i] || cw[i]) ? ~q.sem[i] : 1'b1;
        if (!q.sem[i]) begin
          nxt_q.own[i] = cr[i];
        end
      end else if (hw[i] || cw[i]) begin
        nxt_q.sem[i] = 1'b0;
      end
    end

    // cpu pipeline: decode, then answer from a flop
    nxt_q.c_p1   = cpu_req;
    nxt_q.c_we1  = cpu_we;
    nxt_q.c_sem1 = c_sem;
    nxt_q.c_ram1 = c_ram;
    nxt_q.c_ack  = q.c_p1;
    if (q.c_p1 && !q.c_we1) begin
      nxt_q.c_rdata = q.c_sem1 ? q.c_semv1 : (q.c_ram1 ? ram_b_rdata : `DPS_RSVD_DATA);
    end

    // host access sequence
    case (q.st)
      dps_pkg::DPS_IDLE: begin
        nxt_q.h_doe = 1'b0;
        // sync reads start at phase rise, sync writes take data at phase fall
        if (!q.cs_s && (!q.mode_s ||
            (q.dir_s && e_rise) || (!q.dir_s && e_fall))) begin
          nxt_q.st     = dps_pkg::DPS_ACC;
          nxt_q.h_addr = q.addr_s;
          nxt_q.h_rd   = q.dir_s;
          nxt_q.h_wd   = q.din_s;
          nxt_q.ack_n  = 1'b1;
          nxt_q.ack_oe = !q.mode_s;
        end
      end
      dps_pkg::DPS_ACC: begin
        nxt_q.st = dps_pkg::DPS_DATA;
      end
      dps_pkg::DPS_DATA: begin
        nxt_q.st     = dps_pkg::DPS_HOLD;
        nxt_q.h_dout = h_sem ? q.h_semv : (h_ram ? ram_a_rdata : `DPS_RSVD_DATA);
        nxt_q.ack_n  = q.mode_s;
        nxt_q.h_doe  = q.h_rd && (!q.mode_s || q.e_s);
      end
      dps_pkg::DPS_HOLD: begin
        nxt_q.h_doe = q.h_rd && (!q.mode_s || q.e_s);
        if (q.mode_s && !q.e_s) begin
          nxt_q.st    = dps_pkg::DPS_IDLE;
          nxt_q.h_doe = 1'b0;
        end else if (!q.mode_s && q.cs_s) begin
          nxt_q.st    = dps_pkg::DPS_REL;
          nxt_q.ack_n = 1'b1;
          nxt_q.h_doe = 1'b0;
        end
      end
      dps_pkg::DPS_REL: begin
        nxt_q.st     = dps_pkg::DPS_IDLE;
        nxt_q.ack_oe = 1'b0;
      end
      default: begin
        nxt_q.st = dps_pkg::DPS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q       <= '0;
      q.st    <= dps_pkg::DPS_IDLE;
      q.cs_m  <= 1'b1;
      q.cs_s  <= 1'b1;
      q.ack_n <= 1'b1;
      q.sem   <= `DPS_SEM_RST;
      q.own   <= `DPS_OWN_RST;
    end else begin
      q <= nxt_q;
    end
  end

  assign host_data_out = q.h_dout;
  assign host_data_oe  = q.h_doe;
  assign xfer_ack_n    = q.ack_n;
  assign xfer_ack_oe   = q.ack_oe;
  assign cpu_rdata     = q.c_rdata;
  assign cpu_ack       = q.c_ack;

  property p_wr_clears;
    @(posedge clk_sys) disable iff (!rst_n)
    ((|(cw | hw)) && !(|(cr | hr))) |=> ((q.sem & $past(cw | hw)) == `DPS_ZERO6);
  endproperty
  a_wr_clears: assert property (p_wr_clears) else $error("write left lock set");

  property p_rd_sets;
    @(posedge clk_sys) disable iff (!rst_n)
    ((|(cr | hr)) && !(|(cw | hw))) |=> ((q.sem & $past(cr | hr)) == $past(cr | hr));
  endproperty
  a_rd_sets: assert property (p_rd_sets) else $error("read left lock clear");

  property p_tie_cpu;
    @(posedge clk_sys) disable iff (!rst_n)
    (|(cr & hr & ~q.sem)) |=> (|(q.own & $past(cr & hr))) && q.h_semv[`DPS_SEM_BIT]
      && !q.c_semv1[`DPS_SEM_BIT];
  endproperty
  a_tie_cpu: assert property (p_tie_cpu) else $error("tie not won by cpu");

  property p_cpu_true;
    @(posedge clk_sys) disable iff (!rst_n)
    (|cr) |-> ##2 (cpu_ack && (cpu_rdata[`DPS_SEM_BIT] == $past(|(cr & q.sem), 2))
      && (cpu_rdata[5:0] == `DPS_ZERO6));
  endproperty
  a_cpu_true: assert property (p_cpu_true) else $error("cpu read wrong lock");

  property p_rw_toggle;
    @(posedge clk_sys) disable iff (!rst_n)
    (|((cw & hr) | (hw & cr))) |=>
      (((q.sem ^ $past(q.sem)) & $past((cw & hr) | (hw & cr))) == $past((cw & hr) | (hw & cr)));
  endproperty
  a_rw_toggle: assert property (p_rw_toggle) else $error("lock did not toggle");

  property p_rsvd_ff;
    @(posedge clk_sys) disable iff (!rst_n)
    ($past(q.st) == dps_pkg::DPS_DATA) && q.h_rd && !h_sem && !h_ram
      |-> (q.h_dout == `DPS_RSVD_DATA);
  endproperty
  a_rsvd_ff: assert property (p_rsvd_ff) else $error("reserved read not all ones");

  property p_ack_rel;
    @(posedge clk_sys) disable iff (!rst_n)
    (q.st == dps_pkg::DPS_HOLD) && !q.mode_s && q.cs_s
      |=> (xfer_ack_n && xfer_ack_oe && !host_data_oe) ##1 !xfer_ack_oe;
  endproperty
  a_ack_rel: assert property (p_ack_rel) else $error("acknowledge not released");

  property p_sync_drive;
    @(posedge clk_sys) disable iff (!rst_n)
    host_data_oe && q.mode_s |-> $past(q.e_s);
  endproperty
  a_sync_drive: assert property (p_sync_drive) else $error("data driven in low phase");

endmodule : dps_port

// ===== test/dps_host_model.sv
// Purpose: system processor on the handshake or phase-clocked side of the port
// Assumes: same clock as the device, so the host is never slower
// Notes:   released address and data lines show the inverse of their last value
module dps_host_model (
  // clock
  input  wire logic       clk_sys,
  // acknowledge pin pieces and data enable
  input  wire logic       xfer_ack_n,
  input  wire logic       xfer_ack_oe,
  input  wire logic       host_data_oe,
  // host bus
  output logic            e_clk,
  output logic            host_cs_n,
  output logic            host_dir,
  output logic      [7:0] host_addr,
  output logic      [7:0] host_data_in
);
  timeunit 1ns;
  timeprecision 1ps;

  logic ack_w;
  int   errs = 0;

  // floating acknowledge reads high through its pull-up
  assign ack_w = xfer_ack_oe ? xfer_ack_n : 1'b1;

  initial begin
    e_clk        = 1'b0;
    host_cs_n    = 1'b1;
    host_dir     = 1'b1;
    host_addr    = 8'h00;
    host_data_in = 8'hFF;
  end

  task automatic acc(input logic rd, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(negedge clk_sys);
    host_dir     = rd;
    host_addr    = a;
    host_data_in = d;
    // data settled a cycle before select falls
    @(negedge clk_sys);
    host_cs_n = 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack_w !== 1'b0 && n < 40);
    if (ack_w !== 1'b0) begin
      errs++;
      $display("unexpected at %0t: no acknowledge", $time);
    end
    @(negedge clk_sys);
    host_cs_n    = 1'b1;
    host_addr    = ~a;
    host_data_in = ~d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (xfer_ack_oe !== 1'b0 && n < 8);
    if (xfer_ack_oe !== 1'b0) begin
      errs++;
      $display("unexpected at %0t: acknowledge not floated", $time);
    end
    repeat (2) @(posedge clk_sys);
  endtask : acc

  // one phase-clock bus cycle; the phase clock stands low between cycles
  task automatic sacc(input logic rd, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    host_cs_n    = 1'b0;
    host_dir     = rd;
    host_addr    = a;
    host_data_in = d;
    repeat (4) @(negedge clk_sys);
    e_clk = 1'b1;
    repeat (6) @(negedge clk_sys);
    if (host_data_oe !== rd) begin
      errs++;
      $display("unexpected at %0t: data enable wrong in high phase", $time);
    end
    e_clk = 1'b0;
    repeat (5) @(negedge clk_sys);
    if (host_data_oe !== 1'b0) begin
      errs++;
      $display("unexpected at %0t: data driven in low phase", $time);
    end
    host_cs_n    = 1'b1;
    host_addr    = ~a;
    host_data_in = ~d;
    repeat (2) @(posedge clk_sys);
  endtask : sacc
endmodule : dps_host_model

// ===== test/dps_port_test.sv
// Purpose: self-checking bench of the semaphore and shared ram port
// Assumes: asynchronous host mode except one phase-clocked pass
// Notes:   expected values queued by drivers, checked by a watcher
`include "dps_regs.svh"

module dps_port_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk_sys = 1'b0;
  logic       rst_b = 1'b0;
  logic       cpu_req = 1'b0;
  logic       cpu_we = 1'b0;
  logic [7:0] cpu_addr = 8'h00;
  logic [7:0] cpu_wdata = 8'h00;
  logic [7:0] cpu_rdata, host_data_out, host_addr, host_data_in, a, d;
  logic       cpu_ack, host_data_oe, xfer_ack_n, xfer_ack_oe, host_cs_n, host_dir;
  logic       hl, hl_q = 1'b0;
  logic       sl, sl_q = 1'b0;
  logic       e_clk;
  logic       sync_mode = 1'b0;
  logic [8:0] e;
  logic [8:0] qc[$];
  logic [7:0] qh[$];
  integer     seed = 32'h4D02BB3B;
  int         fail_count = 0;
  int         compares = 0;

  always #20 clk_sys = ~clk_sys;

  dps_port DUT (
    .clk_sys(clk_sys), .rst_b(rst_b), .e_clk(e_clk), .host_sync_mode(sync_mode),
    .host_cs_n(host_cs_n), .host_dir(host_dir), .host_addr(host_addr),
    .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .xfer_ack_n(xfer_ack_n), .xfer_ack_oe(xfer_ack_oe),
    .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack));

  dps_host_model hm (
    .clk_sys(clk_sys), .xfer_ack_n(xfer_ack_n), .xfer_ack_oe(xfer_ack_oe),
    .host_data_oe(host_data_oe), .e_clk(e_clk),
    .host_cs_n(host_cs_n), .host_dir(host_dir), .host_addr(host_addr),
    .host_data_in(host_data_in));

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask : cmp

  task automatic final_report;
    fail_count += hm.errs;
    $display("counts: compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  task automatic cpu_op(input logic we, input logic [7:0] ad, input logic [7:0] wd,
                        input logic [7:0] ex);
    qc.push_back({~we, ex});
    @(negedge clk_sys);
    cpu_req   = 1'b1;
    cpu_we    = we;
    cpu_addr  = ad;
    cpu_wdata = wd;
    @(negedge clk_sys);
    cpu_req = 1'b0;
  endtask : cpu_op

  task automatic host_op(input logic rd, input logic [7:0] ad, input logic [7:0] wd,
                         input logic [7:0] ex);
    if (rd) qh.push_back(ex);
    hm.acc(rd, ad, wd);
  endtask : host_op

  task automatic host_sop(input logic rd, input logic [7:0] ad, input logic [7:0] wd,
                          input logic [7:0] ex);
    if (rd) qh.push_back(ex);
    hm.sacc(rd, ad, wd);
  endtask : host_sop

  task automatic reset_check;
    for (int i = 0; i < 6; i++) begin
      a = `DPS_SEM_FIRST + i[7:0];
      host_op(1'b1, a, 8'h00, (i == 1) ? 8'hC0 : 8'h80);
      cpu_op(1'b0, a, 8'h00, (i == 1) ? 8'h80 : 8'hC0);
    end
    $display("test reset_state done");
  endtask : reset_check

  // results land on registered outputs, so look mid-cycle
  always @(negedge clk_sys) begin
    if (cpu_ack === 1'b1) begin
      if (qc.size() == 0) begin
        cmp(8'h01, 8'h00, "cpu ack without request");
      end else begin
        e = qc.pop_front();
        if (e[8]) cmp(cpu_rdata, e[7:0], "cpu read");
      end
    end
    hl = (xfer_ack_oe === 1'b1) && (xfer_ack_n === 1'b0);
    if (hl && !hl_q && host_dir === 1'b1) begin
      cmp(host_data_out, (qh.size() > 0) ? qh.pop_front() : 8'hXX, "host read");
      cmp({7'h00, host_data_oe}, 8'h01, "host data enable");
    end
    if (hl && !hl_q && host_dir === 1'b0) begin
      cmp({7'h00, host_data_oe}, 8'h00, "host data on write");
    end
    hl_q = hl;
    // phase-clocked reads have no acknowledge: the data enable marks the answer
    sl = (host_data_oe === 1'b1) && (sync_mode === 1'b1);
    if (sl && !sl_q) begin
      cmp(host_data_out, (qh.size() > 0) ? qh.pop_front() : 8'hXX, "host sync read");
    end
    sl_q = sl;
  end

  initial begin
    #(40 * 20000);
    cmp(8'h00, 8'h01, "timeout");
    final_report();
  end

  initial begin
    repeat (16) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (4) @(negedge clk_sys);
    reset_check();
    for (int i = 0; i < 6; i++) begin
      a = `DPS_SEM_FIRST + i[7:0];
      d = 8'($random(seed));
      cpu_op(1'b1, a, d, 8'h00);
      cpu_op(1'b0, a, 8'h00, (i == 1) ? 8'h00 : 8'h40);
      host_op(1'b1, a, 8'h00, 8'h80);
      host_op(1'b0, a, ~d, 8'h00);
      host_op(1'b1, a, 8'h00, 8'h00);
      cpu_op(1'b0, a, 8'h00, 8'h80);
    end
    $display("test semaphore_handover done");
    // writes never overlap a read of the same byte from the other side
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      a = (i == 0) ? 8'h80 : (i == 1) ? 8'hFF : {1'b1, d[6:0]};
      host_op(1'b0, a, d, 8'h00);
      cpu_op(1'b0, a, 8'h00, d);
      cpu_op(1'b1, a, ~d, 8'h00);
      host_op(1'b1, a, 8'h00, ~d);
    end
    $display("test shared_ram done");
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 8'h00 : (i == 1) ? 8'h16 : (i == 2) ? 8'h1D : 8'h7F;
      host_op(1'b0, a, 8'h00, 8'h00);
      host_op(1'b1, a, 8'h00, 8'hFF);
      cpu_op(1'b0, a, 8'h00, 8'hFF);
    end
    $display("test reserved_space done");
    // contested accesses: the cpu request lands on the host's access cycle
    a = `DPS_SEM_FIRST;
    cpu_op(1'b1, a, 8'h00, 8'h00);
    fork
      host_op(1'b1, a, 8'h00, 8'hC0);
      begin
        repeat (4) @(negedge clk_sys);
        cpu_op(1'b0, a, 8'h00, 8'h00);
      end
    join
    fork
      host_op(1'b0, a, 8'h00, 8'h00);
      begin
        repeat (4) @(negedge clk_sys);
        cpu_op(1'b0, a, 8'h00, 8'hC0);
      end
    join
    fork
      host_op(1'b1, a, 8'h00, 8'h00);
      begin
        repeat (4) @(negedge clk_sys);
        cpu_op(1'b1, a, 8'h00, 8'h00);
      end
    join
    cpu_op(1'b0, a, 8'h00, 8'h80);
    $display("test contested_access done");
    // mode strap only changes while the port is idle
    sync_mode = 1'b1;
    repeat (4) @(negedge clk_sys);
    d = 8'($random(seed));
    host_sop(1'b0, 8'h81, d, 8'h00);
    host_sop(1'b1, 8'h81, 8'h00, d);
    host_sop(1'b1, 8'h20, 8'h00, 8'hFF);
    host_sop(1'b1, a, 8'h00, 8'hC0);
    cpu_op(1'b0, 8'h81, 8'h00, d);
    @(negedge clk_sys);
    sync_mode = 1'b0;
    $display("test sync_bus done");
    // second reset in mid-run must preset the semaphores again
    repeat (8) @(negedge clk_sys);
    rst_b = 1'b0;
    repeat (16) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (4) @(negedge clk_sys);
    reset_check();
    repeat (8) @(negedge clk_sys);
    cmp(8'(qc.size()), 8'h00, "cpu answers missing");
    cmp(8'(qh.size()), 8'h00, "host answers missing");
    final_report();
  end
endmodule : dps_port_test
